// file: src/rre_exec.sv
`timescale 1ns/1ns
`default_nettype none
`include "rre_defines.svh"

module rre_exec
    import rre_pkg::*;
(
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    input  wire rre_instr_t                instr_i,
    input  wire logic                      instr_valid_i,
    input  wire logic [`RRE_PC_W-1:0]      stack_top_i,
    input  wire logic [`RRE_DATA_W-1:0]    mem_rd_data_i,
    input  wire logic [5:0]                flags_i,
    output logic                           ready_o,
    output logic                           stack_pop_o,
    output logic [`RRE_PC_W-1:0]           pc_o,
    output logic                           pc_load_o,
    output logic [`RRE_DATA_W-1:0]         acc_o,
    output logic                           global_interrupt_enable_o,
    output rre_mem_wr_t                    mem_wr_o,
    output logic [`RRE_ADDR_W-1:0]         mem_rd_addr_o,
    output logic [5:0]                     flags_o
);

    // ----------------------------------------------------------------
    // Local types
    // ----------------------------------------------------------------
    typedef enum logic {RRE_ST_IDLE, RRE_ST_SECOND} rre_state_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // True when an opcode equals the wanted one
    function automatic logic rre_op_is(
        input rre_op_t op,
        input rre_op_t want
    );
        rre_op_is = (op == want);
    endfunction

    // ----------------------------------------------------------------
    // State and held instruction
    // ----------------------------------------------------------------
    rre_state_t                   state_reg;
    rre_state_t                   state_next;
    rre_instr_t                   held_reg;
    logic                         ready_next;

    // ----------------------------------------------------------------
    // Decode wires
    // ----------------------------------------------------------------
    logic                         take;
    logic                         in_second;
    logic                         in_rot;
    logic                         is_sub_exit;
    logic                         is_sub_exit_val;
    logic                         is_int_exit;
    logic                         is_mem_rot;
    logic                         is_rot_acc;
    logic                         is_return;

    // ----------------------------------------------------------------
    // Datapath wires
    // ----------------------------------------------------------------
    wire  [`RRE_DATA_W-1:0]       rot_val;
    logic [`RRE_DATA_W-1:0]       acc_next;
    logic                         acc_load;
    logic                         gie_next;
    logic [`RRE_PC_W-1:0]         pc_next;
    logic [`RRE_ADDR_W-1:0]       rd_addr_next;
    logic [`RRE_ADDR_W-1:0]       wr_addr_next;
    logic [`RRE_DATA_W-1:0]       wr_data_next;
    rre_mem_wr_t                  mem_wr_next;

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    // Offers are taken only while idle and ready; ready is low out of reset
    assign take            = ready_o
                          && (state_reg == RRE_ST_IDLE)
                          && instr_valid_i
                          && !rre_op_is(instr_i.op, RRE_OP_NONE);
    assign in_second       = (state_reg == RRE_ST_SECOND);
    assign in_rot          = rre_op_is(instr_i.op, RRE_OP_MEM_ROT)
                          || rre_op_is(instr_i.op, RRE_OP_ROT_ACC);
    assign is_sub_exit     = in_second && rre_op_is(held_reg.op, RRE_OP_SUB_EXIT);
    assign is_sub_exit_val = in_second && rre_op_is(held_reg.op, RRE_OP_SUB_EXIT_VAL);
    assign is_int_exit     = in_second && rre_op_is(held_reg.op, RRE_OP_INT_EXIT);
    assign is_mem_rot      = in_second && rre_op_is(held_reg.op, RRE_OP_MEM_ROT);
    assign is_rot_acc      = in_second && rre_op_is(held_reg.op, RRE_OP_ROT_ACC);
    assign is_return       = is_sub_exit || is_sub_exit_val || is_int_exit;

    // ----------------------------------------------------------------
    // Two-cycle sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RRE_ST_IDLE: begin
                if (take) begin
                    state_next = RRE_ST_SECOND;
                end
            end
            RRE_ST_SECOND: begin
                state_next = RRE_ST_IDLE;
            end
            default: begin
                state_next = RRE_ST_IDLE;
            end
        endcase
    end

    assign ready_next = (state_next == RRE_ST_IDLE);

    // ----------------------------------------------------------------
    // Rotate left by one, top bit into bit zero
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `RRE_DATA_W; gi++) begin : g_rot
            assign rot_val[(gi + 1) % `RRE_DATA_W] = mem_rd_data_i[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    assign rd_addr_next = (take && in_rot) ? instr_i.addr : mem_rd_addr_o;
    assign pc_next      = is_return ? stack_top_i : pc_o;
    assign acc_load     = is_sub_exit_val || is_rot_acc;
    assign acc_next     = is_rot_acc ? rot_val : held_reg.imm;
    assign gie_next     = global_interrupt_enable_o || is_int_exit;
    assign wr_addr_next = is_mem_rot ? held_reg.addr : {`RRE_ADDR_W{1'b0}};
    assign wr_data_next = is_mem_rot ? rot_val : {`RRE_DATA_W{1'b0}};
    assign mem_wr_next  = {is_mem_rot, wr_addr_next, wr_data_next};

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= RRE_ST_IDLE;
            ready_o   <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_o   <= ready_next;
        end
    end

    // ----------------------------------------------------------------
    // Held instruction and read address
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            held_reg      <= '0;
            mem_rd_addr_o <= '0;
        end else begin
            if (take) begin
                held_reg <= instr_i;
            end
            mem_rd_addr_o <= rd_addr_next;
        end
    end

    // ----------------------------------------------------------------
    // Program counter and stack pop
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pc_o        <= `RRE_PC_RST;
            pc_load_o   <= 1'b0;
            stack_pop_o <= 1'b0;
        end else begin
            pc_o        <= pc_next;
            pc_load_o   <= is_return;
            stack_pop_o <= is_return;
        end
    end

    // ----------------------------------------------------------------
    // Accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            acc_o <= `RRE_ACC_RST;
        end else if (acc_load) begin
            acc_o <= acc_next;
        end
    end

    // ----------------------------------------------------------------
    // Global interrupt enable
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            global_interrupt_enable_o <= `RRE_GIE_RST;
        end else begin
            global_interrupt_enable_o <= gie_next;
        end
    end

    // ----------------------------------------------------------------
    // Memory write-back
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mem_wr_o <= '0;
        end else begin
            mem_wr_o <= mem_wr_next;
        end
    end

    // ----------------------------------------------------------------
    // Status flags are registered unchanged, one cycle behind flags_i
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flags_o <= `RRE_FLAGS_RST;
        end else begin
            flags_o <= flags_i;
        end
    end

endmodule
`default_nettype wire

// file: src/rre_defines.svh
`ifndef RRE_DEFINES_SVH
`define RRE_DEFINES_SVH
`define RRE_PC_W       14
`define RRE_ADDR_W     10
`define RRE_DATA_W     8
`define RRE_ACC_RST    8'h00
`define RRE_PC_RST     14'h0000
`define RRE_FLAGS_RST  6'h00
`define RRE_GIE_RST    1'b0
`endif

// file: src/rre_pkg.sv
package rre_pkg;
    typedef enum logic [2:0] {
        RRE_OP_NONE,
        RRE_OP_SUB_EXIT,
        RRE_OP_SUB_EXIT_VAL,
        RRE_OP_INT_EXIT,
        RRE_OP_MEM_ROT,
        RRE_OP_ROT_ACC
    } rre_op_t;

    typedef struct packed {
        rre_op_t     op;
        logic [7:0]  imm;
        logic [9:0]  addr;
    } rre_instr_t;

    typedef struct packed {
        logic        wr;
        logic [9:0]  addr;
        logic [7:0]  data;
    } rre_mem_wr_t;
endpackage

// file: dv/rre_exec_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rre_chk import rre_pkg::*; (
    input wire logic        clock_i, rst_i, instr_valid_i, ready_o, stack_pop_o,
    input wire logic        global_interrupt_enable_o,
    input wire logic [7:0]  mem_rd_data_i, acc_o,
    input wire logic [5:0]  flags_i, flags_o,
    input wire rre_instr_t  instr_i,
    input wire rre_mem_wr_t mem_wr_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire rre_op_t tk  = (ready_o && instr_valid_i) ? instr_i.op : RRE_OP_NONE;
    wire [7:0]    rot = {mem_rd_data_i[6:0], mem_rd_data_i[7]};
    AST_POP: assert property (tk == RRE_OP_SUB_EXIT |=>
        !ready_o ##1 ready_o && stack_pop_o) else $error("pop");
    AST_VAL: assert property (tk == RRE_OP_SUB_EXIT_VAL |->
        ##2 acc_o == $past(instr_i.imm, 2)) else $error("val");
    AST_GIE: assert property (tk == RRE_OP_INT_EXIT |->
        ##2 global_interrupt_enable_o && stack_pop_o) else $error("gie");
    AST_MROT: assert property (tk == RRE_OP_MEM_ROT |->
        ##2 mem_wr_o == {1'b1, $past(instr_i.addr, 2), $past(rot)}) else $error("mrot");
    AST_RACC: assert property (tk == RRE_OP_ROT_ACC |->
        ##2 !mem_wr_o.wr && acc_o == $past(rot)) else $error("racc");
    AST_FLG: assert property (!$past(rst_i) |->
        flags_o == $past(flags_i)) else $error("flags");
    AST_POP1: assert property (stack_pop_o |=> !stack_pop_o) else $error("pop pulse");
endmodule
bind rre_exec rre_chk u_chk (
    .clock_i                   (clock_i),
    .rst_i                     (rst_i),
    .instr_valid_i             (instr_valid_i),
    .ready_o                   (ready_o),
    .stack_pop_o               (stack_pop_o),
    .global_interrupt_enable_o (global_interrupt_enable_o),
    .mem_rd_data_i             (mem_rd_data_i),
    .acc_o                     (acc_o),
    .flags_i                   (flags_i),
    .flags_o                   (flags_o),
    .instr_i                   (instr_i),
    .mem_wr_o                  (mem_wr_o)
);
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import rre_pkg::*; ;
    logic clock_i = 0, rst_i = 1, instr_valid_i = 0, ready_o, stack_pop_o;
    logic pc_load_o, global_interrupt_enable_o;
    logic [13:0] stack_top_i = 14'h2abc, pc_o;
    logic [9:0] mem_rd_addr_o;
    logic [7:0] acc_o, mem_rd_data_i;
    logic [5:0] flags_i = 6'h2d, flags_o;
    rre_instr_t instr_i = '0;
    rre_mem_wr_t mem_wr_o;
    int err_total = 0, check_count = 0, cyc = 0;
    assign mem_rd_data_i = mem_rd_addr_o[7:0] ^ 8'h96;
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) if (++cyc == 99) close_out();
    rre_exec dut (
        .clock_i                   (clock_i),
        .rst_i                     (rst_i),
        .instr_i                   (instr_i),
        .instr_valid_i             (instr_valid_i),
        .stack_top_i               (stack_top_i),
        .mem_rd_data_i             (mem_rd_data_i),
        .flags_i                   (flags_i),
        .ready_o                   (ready_o),
        .stack_pop_o               (stack_pop_o),
        .pc_o                      (pc_o),
        .pc_load_o                 (pc_load_o),
        .acc_o                     (acc_o),
        .global_interrupt_enable_o (global_interrupt_enable_o),
        .mem_wr_o                  (mem_wr_o),
        .mem_rd_addr_o             (mem_rd_addr_o),
        .flags_o                   (flags_o)
    );
    task automatic chk(input logic [31:0] g, e);
        check_count++;
        err_total += int'(g !== e);
        if (g !== e) $display("MISMATCH %0t %h %h", $time, g, e);
    endtask
    task automatic run(input rre_op_t op, input logic [9:0] a);
        @(posedge clock_i) #1 instr_i = '{op, 8'hc3, a};
        instr_valid_i = 1;
        @(posedge clock_i) #1 instr_valid_i = 0;
        @(posedge clock_i) #1;
    endtask
    task automatic t_reset_refuse();
        instr_i = '{RRE_OP_SUB_EXIT, 8'hc3, 10'h000};
        instr_valid_i = 1;
        repeat (4) @(posedge clock_i);
        #1 rst_i = 0;
        @(posedge clock_i) #1 instr_valid_i = 0;
        @(posedge clock_i) #1;
        chk({stack_pop_o, pc_load_o, ready_o, pc_o}, {3'h1, 14'h0000});
        $display("reset refuse done");
    endtask
    task automatic t_sub_exit();
        run(RRE_OP_SUB_EXIT, 10'h000);
        chk({stack_pop_o, pc_load_o, ready_o, pc_o}, {3'h7, 14'h2abc});
        $display("sub exit done");
    endtask
    task automatic t_busy();
        @(posedge clock_i) #1 instr_i = '{RRE_OP_SUB_EXIT, 8'hc3, 10'h000};
        instr_valid_i = 1;
        repeat (2) @(posedge clock_i);
        #1 instr_valid_i = 0;
        chk({stack_pop_o, ready_o}, 2'h3);
        @(posedge clock_i) #1;
        chk({stack_pop_o, ready_o}, 2'h1);
        $display("busy done");
    endtask
    task automatic t_sub_exit_val();
        stack_top_i = 14'h1001;
        run(RRE_OP_SUB_EXIT_VAL, 10'h000);
        chk({global_interrupt_enable_o, acc_o, pc_o}, {1'h0, 8'hc3, 14'h1001});
        $display("sub exit val done");
    endtask
    task automatic t_int_exit();
        flags_i = 6'h12;
        run(RRE_OP_INT_EXIT, 10'h000);
        chk({global_interrupt_enable_o, stack_pop_o, flags_o}, {2'h3, 6'h12});
        $display("int exit done");
    endtask
    task automatic t_mem_rot();
        run(RRE_OP_MEM_ROT, 10'h071);
        chk(mem_wr_o, {1'h1, 10'h071, 8'hcf});
        $display("mem rot done");
    endtask
    task automatic t_rot_acc();
        run(RRE_OP_ROT_ACC, 10'h003);
        chk({mem_wr_o.wr, acc_o}, {1'h0, 8'h2b});
        $display("rot acc done");
    endtask
    task automatic close_out();
        err_total += int'(cyc >= 99);
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        t_reset_refuse();
        t_sub_exit();
        t_busy();
        t_sub_exit_val();
        t_int_exit();
        t_mem_rot();
        t_rot_acc();
        close_out();
    end
endmodule
`default_nettype wire
